// ===== design/param_set_sequencer.v
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "param_seq_regs.vh"
// -----------------------------------------------------------------------------
// Automatic parameter set sequencer
// -----------------------------------------------------------------------------
module param_set_sequencer #(
  parameter DW = 32
) (
  input  wire                   i_mclk,
  input  wire                   i_nrst,
  input  wire                   i_srst,        // Synchronous clear
  input  wire                   i_psel,
  input  wire                   i_penable,
  input  wire                   i_pwrite,
  input  wire [`REG_ADDR_W-1:0] i_paddr,
  input  wire [31:0]            i_pwdata,
  output reg  [31:0]            o_prdata,
  output reg                    o_pready,
  output reg                    o_pslverr,
  input  wire                   i_frame_start, // One-cycle trigger pulse
  input  wire                   i_frame_busy,  // Exposure/readout/transmit
  output reg  [DW-1:0]          o_active_param,// Active parameter set
  output reg  [5:0]             o_set_index,   // Set used by current frame
  output reg                    o_seq_running  // Sequencer cycling
);
  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  localparam ST_OFF   = 2'b00;  // Idle
  localparam ST_LOAD0 = 2'b01;  // Fetching set 0
  localparam ST_RUN   = 2'b10;  // Cycling on triggers
  localparam ST_LOADN = 2'b11;  // Fetching next set
  // Flow: OFF waits for the switch, LOAD0 fetches set 0, RUN counts uses
  // per trigger, LOADN lands the next set. Memory reads take one cycle,
  // so each load state only exists to let the registered read settle.

  reg  [1:0]    state_ff;         // Sequencer state
  reg  [1:0]    nxt_state;
  reg           sequencer_on_ff;  // Software switch
  reg           set_step_policy_ff; // 1 = automatic
  reg  [6:0]    set_cycle_length_ff;
  reg  [5:0]    set_select_index_ff;
  reg  [8:0]    set_repeat_count_ff;
  reg  [DW-1:0] active_ff;        // Active parameters
  reg  [DW-1:0] saved_ff;         // Values before switch-on
  reg  [5:0]    cur_idx_ff;       // Current set index
  reg  [8:0]    use_cnt_ff;       // Uses of current set, up to 256
  reg  [8:0]    cur_rep_ff;       // Repeat count of current set
  reg  [5:0]    nxt_idx;
  reg  [5:0]    rd_idx;           // Memory read index
  reg           save_wr;          // Memory write strobe

  wire wr_ctrl, wr_len, wr_idx, wr_rep, wr_act, wr_cmd, rd_hit, slverr;
  wire [DW-1:0] mem_data;
  wire [8:0]    mem_rep;
  wire          mem_valid;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Clamp cycle length into 1..64
  function [6:0] clamp_len;
    input [31:0] v;
    begin
      if (v[6:0] == 7'h00 || v > {25'h0000000, `CYCLE_LEN_MAX}) begin
        clamp_len = (v[6:0] == 7'h00 && v < 32'h00000080) ? `CYCLE_LEN_RST
                                                           : `CYCLE_LEN_MAX;
      end else begin
        clamp_len = v[6:0];
      end
    end
  endfunction

  // Clamp repeat count into 1..256
  function [8:0] clamp_rep;
    input [31:0] v;
    begin
      if (v == 32'h00000000) begin
        clamp_rep = `REPEAT_RST;
      end else if (v > {23'h000000, `REPEAT_MAX}) begin
        clamp_rep = `REPEAT_MAX;
      end else begin
        clamp_rep = v[8:0];
      end
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Bus front end and set memory
  // ---------------------------------------------------------------------------
  apb_slave_regs u_apb (
    .i_mclk    (i_mclk),
    .i_nrst    (i_nrst),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .o_wr_ctrl (wr_ctrl),
    .o_wr_len  (wr_len),
    .o_wr_idx  (wr_idx),
    .o_wr_rep  (wr_rep),
    .o_wr_act  (wr_act),
    .o_wr_cmd  (wr_cmd),
    .o_rd_hit  (rd_hit),
    .o_slverr  (slverr)
  );

  // Saves carry the repeat count too, so each set owns its count
  // Save only while off, so a running cycle is never disturbed
  always @* begin
    save_wr = wr_cmd & i_pwdata[`CMD_SAVE_BIT] & (state_ff == ST_OFF);
  end

  set_store_mem #(.DW(DW), .AW(6)) u_mem (
    .i_mclk   (i_mclk),
    .i_nrst   (i_nrst),
    .i_wr     (save_wr),
    .i_waddr  (set_select_index_ff),
    .i_wdata  (active_ff),
    .i_wrep   (set_repeat_count_ff),
    .i_raddr  (rd_idx),
    .o_rdata  (mem_data),
    .o_rrep   (mem_rep),
    .o_rvalid (mem_valid)
  );

  // ---------------------------------------------------------------------------
  // Next set index and read address
  // ---------------------------------------------------------------------------
  // Wrap after the last set of the cycle
  // A cycle length of one pins the index at zero
  always @* begin
    if ({1'b0, cur_idx_ff} + 7'h01 >= set_cycle_length_ff) begin
      nxt_idx = 6'h00;
    end else begin
      nxt_idx = cur_idx_ff + 6'h01;
    end
    // Memory is prefetched with the candidate next set
    if (state_ff == ST_OFF || state_ff == ST_LOAD0) begin
      rd_idx = 6'h00;
    end else begin
      rd_idx = nxt_idx;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer state machine
  // ---------------------------------------------------------------------------
  // A set is spent once its uses reach its repeat count. The compare is
  // >= rather than == so a count that is ever exceeded still advances
  // instead of stalling the cycle on one set for good.
  wire exhausted = (use_cnt_ff >= cur_rep_ff);
  wire stop_req  = !sequencer_on_ff;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: begin
        if (sequencer_on_ff && set_step_policy_ff == `POLICY_AUTO) begin
          nxt_state = ST_LOAD0;
        end
      end
      ST_LOAD0: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        // Hold the cycle until the current frame is out
        // A pending switch-off also blocks new triggers, so no set is
        // fetched for a frame that the stop would cut short
        if (stop_req && !i_frame_busy) begin
          nxt_state = ST_OFF;
        end else if (!stop_req && i_frame_start && exhausted) begin
          nxt_state = ST_LOADN;
        end
      end
      ST_LOADN: begin
        nxt_state = ST_RUN;
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  // Fetched word, or default for never-saved sets
  // Memory words have no reset, so the written flag keeps X off the pins
  wire [DW-1:0] fetched = mem_valid ? mem_data : `SET_DEFAULT;
  wire [8:0]    f_rep   = mem_valid ? mem_rep  : `REPEAT_RST;

  // ---------------------------------------------------------------------------
  // Sequencer datapath
  // ---------------------------------------------------------------------------
  // Trigger in RUN with uses remaining counts a reuse; an exhausted set
  // fetches the next one. Since memory read is prefetched at nxt_idx the
  // new set lands one cycle after the trigger, limitation: a frame must not
  // sample active parameters in that very cycle.
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff    <= ST_OFF;
      cur_idx_ff  <= 6'h00;
      use_cnt_ff  <= 9'h000;
      cur_rep_ff  <= `REPEAT_RST;
      active_ff   <= {DW{1'b0}};
      saved_ff    <= {DW{1'b0}};
    end else if (i_srst) begin
      state_ff    <= ST_OFF;
      cur_idx_ff  <= 6'h00;
      use_cnt_ff  <= 9'h000;
      cur_rep_ff  <= `REPEAT_RST;
    end else begin
      state_ff <= nxt_state;
      case (state_ff)
        ST_OFF: begin
          if (nxt_state == ST_LOAD0) begin
            saved_ff <= active_ff;                     // Kept for restore
          end else if (wr_act) begin
            active_ff <= i_pwdata[DW-1:0];
          end
        end
        ST_LOAD0: begin
          active_ff  <= fetched;
          cur_idx_ff <= 6'h00;
          cur_rep_ff <= f_rep;
          use_cnt_ff <= 9'h000;
        end
        ST_RUN: begin
          if (nxt_state == ST_OFF) begin
            active_ff  <= saved_ff;
            cur_idx_ff <= 6'h00;
            use_cnt_ff <= 9'h000;
          end else if (i_frame_start && !stop_req && !exhausted) begin
            use_cnt_ff <= use_cnt_ff + 9'h001;
          end
        end
        ST_LOADN: begin
          // Prefetch address still equals the set being entered
          active_ff  <= fetched;
          cur_idx_ff <= rd_idx;
          cur_rep_ff <= f_rep;
          use_cnt_ff <= 9'h001;                        // Trigger counts as first use
        end
        default: begin
          active_ff <= active_ff;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // Configuration writes other than the on switch bit are ignored while cycling
  // Trade-off: refused writes are dropped silently rather than flagged,
  // so software must read a field back to learn whether it stuck.
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sequencer_on_ff     <= 1'b0;
      set_step_policy_ff  <= `POLICY_AUTO;
      set_cycle_length_ff <= `CYCLE_LEN_RST;
      set_select_index_ff <= 6'h00;
      set_repeat_count_ff <= `REPEAT_RST;
    end else if (i_srst) begin
      sequencer_on_ff     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        sequencer_on_ff <= i_pwdata[`CTRL_ON_BIT];
        if (state_ff == ST_OFF) begin
          set_step_policy_ff <= i_pwdata[`CTRL_POLICY_BIT];
        end
      end
      if (state_ff == ST_OFF) begin
        if (wr_len) begin
          set_cycle_length_ff <= clamp_len(i_pwdata);
        end
        if (wr_idx) begin
          set_select_index_ff <= i_pwdata[5:0];
        end
        if (wr_rep) begin
          set_repeat_count_ff <= clamp_rep(i_pwdata);
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux and registered outputs
  // ---------------------------------------------------------------------------
  // Read data registered: valid in the access phase one cycle after setup
  // Status mirrors internal state, one cycle ahead of the pin outputs
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata       <= 32'h00000000;
      o_pready       <= 1'b0;
      o_pslverr      <= 1'b0;
      o_active_param <= {DW{1'b0}};
      o_set_index    <= 6'h00;
      o_seq_running  <= 1'b0;
    end else begin
      // pready one cycle after setup: no wait states per transfer
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        o_pslverr <= 1'b0;
        case (i_paddr)
          `REG_CTRL:      o_prdata <= {30'h00000000, set_step_policy_ff, sequencer_on_ff};
          `REG_CYCLE_LEN: o_prdata <= {25'h0000000, set_cycle_length_ff};
          `REG_SEL_INDEX: o_prdata <= {26'h0000000, set_select_index_ff};
          `REG_REPEAT:    o_prdata <= {23'h000000, set_repeat_count_ff};
          `REG_ACTIVE:    o_prdata <= active_ff;
          `REG_CMD:       o_prdata <= 32'h00000000;
          `REG_STATUS:    o_prdata <= {7'h00, use_cnt_ff, 2'h0, cur_idx_ff, 6'h00,
                                       i_frame_busy, (state_ff != ST_OFF)};
          default: begin
            o_prdata  <= 32'h00000000;
            o_pslverr <= 1'b1;
          end
        endcase
      end
      o_active_param <= active_ff;
      o_set_index    <= cur_idx_ff;
      o_seq_running  <= (state_ff != ST_OFF);
    end
  end

  wire unused_ok = rd_hit | slverr;  // Decode also drives write strobes

endmodule // param_set_sequencer

// ===== design/param_seq_regs.vh
`ifndef PARAM_SEQ_REGS_VH
`define PARAM_SEQ_REGS_VH
// -----------------------------------------------------------------------------
// Register map (APB byte addresses)
// -----------------------------------------------------------------------------
`define REG_CTRL        12'h000
`define REG_CYCLE_LEN   12'h004
`define REG_SEL_INDEX   12'h008
`define REG_REPEAT      12'h00C
`define REG_ACTIVE      12'h010
`define REG_CMD         12'h014
`define REG_STATUS      12'h018
`define REG_ADDR_W      12
// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define CTRL_ON_BIT     0
`define CTRL_POLICY_BIT 1
`define CMD_SAVE_BIT    0
`define STAT_RUN_BIT    0
`define STAT_FRAME_BIT  1
`define STAT_IDX_LSB    8
`define STAT_USE_LSB    16
// -----------------------------------------------------------------------------
// Reset and limit values
// -----------------------------------------------------------------------------
`define POLICY_AUTO     1'h1
`define CYCLE_LEN_RST   7'h01
`define CYCLE_LEN_MAX   7'h40
`define REPEAT_RST      9'h001
`define REPEAT_MAX      9'h100
`define SET_DEFAULT     32'h00000000
`endif

// ===== design/set_store_mem.v
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Stored parameter set memory, registered read, per-entry written flag
// -----------------------------------------------------------------------------
module set_store_mem #(
  parameter DW = 32,
  parameter AW = 6
) (
  input  wire          i_mclk,
  input  wire          i_nrst,
  input  wire          i_wr,      // Write strobe
  input  wire [AW-1:0] i_waddr,   // Write index
  input  wire [DW-1:0] i_wdata,   // Parameter word
  input  wire [8:0]    i_wrep,    // Repeat count
  input  wire [AW-1:0] i_raddr,   // Read index
  output reg  [DW-1:0] o_rdata,   // Registered parameter word
  output reg  [8:0]    o_rrep,    // Registered repeat count
  output reg           o_rvalid   // Entry was ever written
);
  reg [DW-1:0]       data_mem [0:(1<<AW)-1];  // Parameter words
  reg [8:0]          rep_mem  [0:(1<<AW)-1];  // Repeat counts
  reg [(1<<AW)-1:0]  written_ff;              // Written flags, reset clears

  // Flags need reset so unwritten sets read as defaults
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      written_ff <= {(1<<AW){1'b0}};
    end else if (i_wr) begin
      written_ff[i_waddr] <= 1'b1;
    end
  end

  // Memory arrays without reset, friendlier to RAM inference
  always @(posedge i_mclk) begin
    if (i_wr) begin
      data_mem[i_waddr] <= i_wdata;
      rep_mem[i_waddr]  <= i_wrep;
    end
  end

  // Registered read port
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata  <= {DW{1'b0}};
      o_rrep   <= 9'h000;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata  <= data_mem[i_raddr];
      o_rrep   <= rep_mem[i_raddr];
      o_rvalid <= written_ff[i_raddr];
    end
  end
endmodule // set_store_mem

// ===== design/apb_slave_regs.v
`timescale 1ns/1ps
`include "param_seq_regs.vh"
// -----------------------------------------------------------------------------
// APB slave front end: zero-wait, decodes one write strobe per register except status
// -----------------------------------------------------------------------------
module apb_slave_regs (
  input  wire                    i_mclk,
  input  wire                    i_nrst,
  input  wire                    i_psel,
  input  wire                    i_penable,
  input  wire                    i_pwrite,
  input  wire [`REG_ADDR_W-1:0]  i_paddr,
  output reg                     o_wr_ctrl,    // One-cycle write strobes
  output reg                     o_wr_len,
  output reg                     o_wr_idx,
  output reg                     o_wr_rep,
  output reg                     o_wr_act,
  output reg                     o_wr_cmd,
  output reg                     o_rd_hit,     // Any mapped address, read or write, and unmapped outside access
  output reg                     o_slverr      // Unmapped address
);
  wire acc = i_psel & i_penable;  // Access phase

  // Address decode, combinational; pready is registered in the sequencer
  always @* begin
    o_wr_ctrl = 1'b0;
    o_wr_len  = 1'b0;
    o_wr_idx  = 1'b0;
    o_wr_rep  = 1'b0;
    o_wr_act  = 1'b0;
    o_wr_cmd  = 1'b0;
    o_rd_hit  = 1'b0;
    o_slverr  = 1'b0;
    case (i_paddr)
      `REG_CTRL:      o_wr_ctrl = acc & i_pwrite;
      `REG_CYCLE_LEN: o_wr_len  = acc & i_pwrite;
      `REG_SEL_INDEX: o_wr_idx  = acc & i_pwrite;
      `REG_REPEAT:    o_wr_rep  = acc & i_pwrite;
      `REG_ACTIVE:    o_wr_act  = acc & i_pwrite;
      `REG_CMD:       o_wr_cmd  = acc & i_pwrite;
      `REG_STATUS:    o_rd_hit  = 1'b1;
      default:        o_slverr  = acc;   // Unmapped: error, no effect
    endcase
    if (i_paddr != `REG_STATUS && !o_slverr) begin
      o_rd_hit = 1'b1;
    end
  end
endmodule // apb_slave_regs

// ===== test/param_seq_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the set sequencer
// ----------------------------------------
module param_seq_properties #(
  parameter DW = 32
) (
  input wire logic          i_mclk,
  input wire logic          i_nrst,
  input wire logic          i_srst,
  input wire logic          i_psel,
  input wire logic          i_penable,
  input wire logic          o_pready,
  input wire logic          o_pslverr,
  input wire logic          i_frame_start,
  input wire logic          i_frame_busy,
  input wire logic [DW-1:0] o_active_param,
  input wire logic [5:0]    o_set_index,
  input wire logic          o_seq_running
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  // Bus phases
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable && o_pready;
  endsequence

  property p_ready_one;
    s_setup |=> s_access;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("no ready in access cycle");
  property p_ready_only;
    o_pready |-> i_penable && !$past(i_penable);
  endproperty
  a_ready_only: assert property (p_ready_only)
    else $error("ready outside first access cycle");
  property p_err_ready;
    o_pslverr |-> o_pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("slave error without ready");
  // Clear lands two samples later because outputs lag state
  property p_srst;
    i_srst |=> ##1 (!o_seq_running && o_set_index == 6'h00);
  endproperty
  a_srst: assert property (p_srst)
    else $error("clear did not stop sequencer");
  property p_first_zero;
    $rose(o_seq_running) |-> o_set_index == 6'h00;
  endproperty
  a_first_zero: assert property (p_first_zero)
    else $error("start not on set zero");
  property p_stop_zero;
    $fell(o_seq_running) |-> o_set_index == 6'h00;
  endproperty
  a_stop_zero: assert property (p_stop_zero)
    else $error("stop did not return index");
  property p_busy_hold;
    o_seq_running && i_frame_busy && $past(i_frame_busy) && !i_srst && !$past(i_srst)
      |=> o_seq_running;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("stopped during a frame");
  // Index may move only shortly after a trigger
  property p_idx_hold;
    o_seq_running && $past(o_seq_running) && !$past(i_frame_start)
      && !$past(i_frame_start, 2) && !$past(i_frame_start, 3) |-> $stable(o_set_index);
  endproperty
  a_idx_hold: assert property (p_idx_hold)
    else $error("index moved without trigger");
  property p_idx_step;
    o_seq_running && $past(o_seq_running) && o_set_index != $past(o_set_index)
      |-> o_set_index == ($past(o_set_index) + 6'h01) || o_set_index == 6'h00;
  endproperty
  a_idx_step: assert property (p_idx_step)
    else $error("index skipped a set");
endmodule // param_seq_properties

bind param_set_sequencer param_seq_properties #(.DW(DW)) u_param_seq_properties (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_frame_start(i_frame_start), .i_frame_busy(i_frame_busy),
  .o_active_param(o_active_param), .o_set_index(o_set_index),
  .o_seq_running(o_seq_running));

// ===== test/frame_src_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Frame trigger source
// ----------------------------------------
module frame_src_model (
  input  wire logic i_mclk,
  output logic      o_frame_start,  // One-cycle trigger
  output logic      o_frame_busy    // Exposure and transmit
);
  initial begin
    o_frame_start = 1'b0;
    o_frame_busy  = 1'b0;
  end

  // Pulse then busy for a chosen time; gap keeps triggers apart
  task frame(input logic [31:0] busy_len);
    o_frame_start <= 1'b1;
    o_frame_busy  <= 1'b1;
    @(posedge i_mclk);
    o_frame_start <= 1'b0;
    repeat (busy_len) @(posedge i_mclk);
    o_frame_busy <= 1'b0;
    @(posedge i_mclk);
  endtask

  // Long frame held by the caller
  task hold(input logic v);
    o_frame_busy <= v;
  endtask
endmodule // frame_src_model

// ===== test/auto_parameter_set_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "param_seq_regs.vh"
module auto_parameter_set_sequencer_tb_top;
  logic        mclk = 1'b0;
  logic        nrst, srst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, act, rdat, pre;
  logic        pready, pslverr, fstart, fbusy, run, rerr;
  logic [5:0]  idx;
  logic [31:0] rng = 32'h00000023;  // Fixed seed
  logic [31:0] val [0:4];           // Stored words
  logic [8:0]  rep [0:4];           // Repeat counts
  integer      err_count = 0;
  integer      cmp_count = 0;
  integer      i, n, cur, uses;

  always #50 mclk = ~mclk;

  param_set_sequencer #(.DW(32)) u_param_set_sequencer (
    .i_mclk(mclk), .i_nrst(nrst), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_frame_start(fstart),
    .i_frame_busy(fbusy), .o_active_param(act), .o_set_index(idx), .o_seq_running(run));
  frame_src_model u_frame_src_model (
    .i_mclk(mclk), .o_frame_start(fstart), .o_frame_busy(fbusy));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Expected value of a clamped count field
  function logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  task finish_test();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count = err_count + 1;
    end
  endtask

  // One transfer; idle edge after it so strobes never double up
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 16) begin
      @(posedge mclk);
      k = k + 1;
    end
    if (pready !== 1'b1) begin
      err_count = err_count + 1;
      finish_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    srst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk(act, 32'h0);
    chk(run, 32'h0);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rdat, 32'h2);
    apb(1'b0, 12'h040, 32'h0);
    chk(rerr, 32'h1);
    // Edge values first, then random counts
    for (i = 0; i < 6; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 32'h1FF : xs() % 300;
      apb(1'b1, `REG_REPEAT, n);
      apb(1'b0, `REG_REPEAT, 32'h0);
      chk(rdat, clamp(n, 1, 256));
      apb(1'b1, `REG_CYCLE_LEN, n);
      apb(1'b0, `REG_CYCLE_LEN, 32'h0);
      chk(rdat, clamp(n, 1, 64));
    end
    apb(1'b1, `REG_SEL_INDEX, 32'h3F);
    apb(1'b0, `REG_SEL_INDEX, 32'h0);
    chk(rdat, 32'h3F);
    // Five sets, last one never saved
    apb(1'b1, `REG_CTRL, 32'h2);
    apb(1'b1, `REG_CYCLE_LEN, 32'h5);
    for (i = 0; i < 5; i++) begin
      val[i] = (i < 4) ? xs() : `SET_DEFAULT;
      rep[i] = (i == 1) ? 9'h003 : (i < 4) ? 9'h001 + xs() % 3 : `REPEAT_RST;
    end
    // Stale word in set 0, overwritten by the loop below
    apb(1'b1, `REG_SEL_INDEX, 32'h0);
    apb(1'b1, `REG_ACTIVE, ~val[0]);
    apb(1'b1, `REG_CMD, 32'h1);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `REG_ACTIVE, val[i]);
      apb(1'b1, `REG_REPEAT, rep[i]);
      apb(1'b1, `REG_SEL_INDEX, i);
      apb(1'b1, `REG_CMD, 32'h1);
    end
    pre = xs();
    apb(1'b1, `REG_ACTIVE, pre);
    apb(1'b1, `REG_CTRL, 32'h3);
    repeat (4) @(posedge mclk);
    chk(act, val[0]);
    chk(run, 32'h1);
    cur = 0;
    uses = 0;
    // Over two full cycles with random frame lengths
    for (i = 0; i < 30; i++) begin
      u_frame_src_model.frame(xs() % 4);
      if (uses < rep[cur])
        uses = uses + 1;
      else begin
        cur = (cur + 1) % 5;
        uses = 1;
      end
      repeat (2) @(posedge mclk);
      chk(idx, cur);
      chk(act, val[cur]);
    end
    // Status word mirrors use counter, index and running flag
    apb(1'b0, `REG_STATUS, 32'h0);
    n = (uses << `STAT_USE_LSB) | (cur << `STAT_IDX_LSB) | (1 << `STAT_RUN_BIT);
    chk(rdat, n);
    apb(1'b1, `REG_CYCLE_LEN, 32'h2);
    apb(1'b0, `REG_CYCLE_LEN, 32'h0);
    chk(rdat, 32'h5);
    // Switch off while a frame is in flight
    u_frame_src_model.hold(1'b1);
    apb(1'b1, `REG_CTRL, 32'h2);
    repeat (3) @(posedge mclk);
    chk(run, 32'h1);
    u_frame_src_model.hold(1'b0);
    n = 0;
    while (run !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n = n + 1;
    end
    chk(run, 32'h0);
    chk(act, pre);
    chk(idx, 32'h0);
    // Synchronous clear while running
    apb(1'b1, `REG_CTRL, 32'h3);
    repeat (4) @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(run, 32'h0);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rdat[0], 32'h0);
    finish_test();
  end
endmodule // auto_parameter_set_sequencer_tb_top
